// *** common/vac_cfg.svh ***
// Purpose: constants of the vector axis counter block
// Assumes: 16-bit processor i/o addresses, 16-bit data
// Notes: included by the package, the assertions and the bench
`ifndef VAC_CFG_SVH
`define VAC_CFG_SVH

`define VAC_AW 16
`define VAC_DW 16
`define VAC_SW 12

// register offsets
`define VAC_OFF_BUF 16'hF700
`define VAC_OFF_CTL 16'hF702
`define VAC_OFF_STS 16'hF704
`define VAC_OFF_STEP 16'hF706
`define VAC_OFF_DY 16'hF708
`define VAC_OFF_Y 16'hF70A
`define VAC_OFF_X 16'hF70C

// axis control fields
`define VAC_CTL_XDIR 0
`define VAC_CTL_YDIR 1
`define VAC_CTL_RST 16'h0000

// status fields
`define VAC_STS_ACT 0
`define VAC_STS_FIRST 1
`define VAC_STS_EMPTY 2
`define VAC_STS_PEMPTY 3
`define VAC_STS_XIN 4
`define VAC_STS_YIN 5

// on-screen check looks at this many top bits
`define VAC_TOP_BITS 3

`endif

// *** common/vac_pkg.sv ***
// Purpose: types of the vector axis counter block
// Assumes: vac_cfg.svh on the include path
// Notes: controls arrive from the state controller and slope generator
`include "vac_cfg.svh"

package vac_pkg;

    typedef logic [`VAC_AW-1:0] vac_addr_t;
    typedef logic [`VAC_DW-1:0] vac_word_t;
    typedef logic [`VAC_SW-1:0] vac_step_t;

    // controls from the state controller, active high; the load strobes last one cycle, the count and detect enables and y_select are held
    typedef struct packed {
        logic x_axis_load_strobe;
        logic y_load;
        logic dy_load;
        logic x_count_enable;
        logic empty_detect_enable;
        logic y_select;
    } vac_ctl_t;

    // requests from the slope generator
    typedef struct packed {
        logic x_step_request;
        logic y_step_request;
    } vac_slope_t;

    // register bus request
    typedef struct packed {
        vac_addr_t addr;
        vac_word_t wdata;
        logic wr;
        logic rd;
    } vac_bus_t;

    // read decode result
    typedef enum logic [2:0] {
        VAC_SEL_NONE,
        VAC_SEL_BUF,
        VAC_SEL_CTL,
        VAC_SEL_STS,
        VAC_SEL_STEP,
        VAC_SEL_DY,
        VAC_SEL_Y,
        VAC_SEL_X
    } vac_sel_t;

endpackage

// *** hw/vac_axis_counters.sv ***
// Purpose: x, y and delta-y axis counters of the vector drawing engine
// Assumes: controls and slope requests come from logic on clock_i
// Notes: all outputs are registered, one cycle behind their cause; first_step_o and vector_active_o follow the x load by two cycles
`timescale 1ns/1ps
`default_nettype none

module vac_axis_counters
    import vac_pkg::*;
#(
    parameter int DW = `VAC_DW,
    parameter int SW = `VAC_SW
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire vac_bus_t bus_i,
    output logic [DW-1:0] rdata_o,
    input wire vac_ctl_t ctl_i,
    input wire vac_slope_t slope_i,
    output logic x_on_screen_flag_o,
    output logic y_on_screen_flag_n_o,
    output logic x_axis_read_strobe_o,
    output logic y_axis_read_strobe_o,
    output logic dy_axis_read_strobe_o,
    output logic count_empty_flag_o,
    output logic pixel_count_empty_flag_o,
    output logic y_count_enable_o,
    output logic x_carry_out_n_o,
    output logic first_step_o,
    output logic vector_active_o,
    output logic vector_end_o,
    output logic [DW-1:0] display_bus_o,
    output logic x_step_request_test_n_o,
    output logic y_step_request_test_n_o,
    output logic x_direction_test_n_o,
    output logic y_direction_test_n_o
);

    ////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    logic rst_n;
    assign rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic vac_sel_t decode(input vac_addr_t a);
        vac_sel_t s;
        s = VAC_SEL_NONE;
        unique case (a)
            `VAC_OFF_BUF: s = VAC_SEL_BUF;
            `VAC_OFF_CTL: s = VAC_SEL_CTL;
            `VAC_OFF_STS: s = VAC_SEL_STS;
            `VAC_OFF_STEP: s = VAC_SEL_STEP;
            `VAC_OFF_DY: s = VAC_SEL_DY;
            `VAC_OFF_Y: s = VAC_SEL_Y;
            `VAC_OFF_X: s = VAC_SEL_X;
            default: s = VAC_SEL_NONE;
        endcase
        return s;
    endfunction

    vac_sel_t wsel;
    vac_sel_t rsel;
    assign wsel = bus_i.wr ? decode(bus_i.addr) : VAC_SEL_NONE;
    assign rsel = bus_i.rd ? decode(bus_i.addr) : VAC_SEL_NONE;

    ////////////////////////////////////////////////////////////////////
    // software registers

    logic [DW-1:0] buf_q;
    logic [DW-1:0] ctl_q;
    logic [SW-1:0] step_load_q;

    // buffer latch holds the last value the processor wrote
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '0;
        end else if (ce_i && wsel == VAC_SEL_BUF) begin
            buf_q <= bus_i.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `VAC_CTL_RST;
        end else if (ce_i && wsel == VAC_SEL_CTL) begin
            ctl_q <= bus_i.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            step_load_q <= '0;
        end else if (ce_i && wsel == VAC_SEL_STEP) begin
            step_load_q <= bus_i.wdata[SW-1:0];
        end
    end

    logic x_dir;
    logic y_dir;
    assign x_dir = ctl_q[`VAC_CTL_XDIR];
    assign y_dir = ctl_q[`VAC_CTL_YDIR];

    ////////////////////////////////////////////////////////////////////
    // counter control

    logic active_q;
    logic step_zero;
    logic x_go;
    logic y_go;

    // x count needs the state controller enable and a slope request;
    // an empty step counter stops both axes at once, no overshoot step
    assign x_go = ctl_i.x_count_enable & slope_i.x_step_request & active_q & ~step_zero;
    assign y_go = ctl_i.x_count_enable & slope_i.y_step_request & active_q & ~step_zero;

    ////////////////////////////////////////////////////////////////////
    // axis counters

    logic [DW-1:0] x_q;
    logic [DW-1:0] y_q;
    logic [DW-1:0] dy_q;
    logic [DW-1:0] pix_q;
    logic [SW-1:0] step_q;
    logic first_q;

    // one unit per enabled cycle, direction bit set means down
    function automatic logic [DW-1:0] step1(
        input logic [DW-1:0] v,
        input logic down
    );
        return down ? v - 1'b1 : v + 1'b1;
    endfunction

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= '0;
        end else if (ce_i) begin
            if (ctl_i.x_axis_load_strobe) begin
                x_q <= buf_q;
            end else if (x_go) begin
                x_q <= step1(x_q, x_dir);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pix_q <= '0;
        end else if (ce_i) begin
            if (ctl_i.x_axis_load_strobe) begin
                pix_q <= buf_q;
            end else if (x_go && pix_q != '0) begin
                pix_q <= pix_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            y_q <= '0;
        end else if (ce_i) begin
            if (ctl_i.y_load) begin
                y_q <= buf_q;
            end else if (y_go) begin
                y_q <= step1(y_q, y_dir);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            dy_q <= '0;
        end else if (ce_i) begin
            if (ctl_i.dy_load) begin
                dy_q <= buf_q;
            end else if (y_go) begin
                dy_q <= step1(dy_q, y_dir);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b0;
        end else if (ce_i) begin
            if (ctl_i.x_axis_load_strobe) begin
                first_q <= 1'b1;
            end else if (ctl_i.x_count_enable) begin
                first_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step counter and vector termination

    logic any_go;
    assign any_go = x_go | y_go;
    assign step_zero = (step_q == '0);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= '0;
        end else if (ce_i) begin
            if (ctl_i.x_axis_load_strobe) begin
                step_q <= step_load_q;
            end else if (any_go && !step_zero) begin
                step_q <= step_q - 1'b1;
            end
        end
    end

    // vector runs from x load until the step counter empties
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (ce_i) begin
            if (ctl_i.x_axis_load_strobe) begin
                active_q <= 1'b1;
            end else if (active_q && step_zero) begin
                active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            vector_end_o <= 1'b0;
        end else if (ce_i) begin
            vector_end_o <= active_q & step_zero & ~ctl_i.x_axis_load_strobe;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            vector_active_o <= 1'b0;
            first_step_o <= 1'b0;
        end else if (ce_i) begin
            vector_active_o <= active_q;
            first_step_o <= first_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags to the state controller

    logic x_carry;
    assign x_carry = x_go & (x_dir ? (x_q == '0) : (x_q == '1));

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            x_on_screen_flag_o <= 1'b0;
            y_on_screen_flag_n_o <= 1'b1;
        end else if (ce_i) begin
            x_on_screen_flag_o <= (x_q[DW-1 -: `VAC_TOP_BITS] == '0);
            y_on_screen_flag_n_o <= (y_q[DW-1 -: `VAC_TOP_BITS] != '0);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            count_empty_flag_o <= 1'b0;
            pixel_count_empty_flag_o <= 1'b0;
        end else if (ce_i) begin
            count_empty_flag_o <= ctl_i.empty_detect_enable & step_zero;
            pixel_count_empty_flag_o <= ctl_i.empty_detect_enable & (pix_q == '0);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            y_count_enable_o <= 1'b0;
            x_carry_out_n_o <= 1'b1;
        end else if (ce_i) begin
            y_count_enable_o <= y_go;
            x_carry_out_n_o <= ~x_carry;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display bus and test points

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            display_bus_o <= '0;
        end else if (ce_i) begin
            display_bus_o <= ctl_i.y_select ? y_q : dy_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            x_step_request_test_n_o <= 1'b1;
            y_step_request_test_n_o <= 1'b1;
            x_direction_test_n_o <= 1'b1;
            y_direction_test_n_o <= 1'b1;
        end else if (ce_i) begin
            x_step_request_test_n_o <= ~slope_i.x_step_request;
            y_step_request_test_n_o <= ~slope_i.y_step_request;
            x_direction_test_n_o <= ~x_dir;
            y_direction_test_n_o <= ~y_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    logic [DW-1:0] sts;
    always_comb begin
        sts = '0;
        sts[`VAC_STS_ACT] = active_q;
        sts[`VAC_STS_FIRST] = first_q;
        sts[`VAC_STS_EMPTY] = step_zero;
        sts[`VAC_STS_PEMPTY] = (pix_q == '0);
        sts[`VAC_STS_XIN] = (x_q[DW-1 -: `VAC_TOP_BITS] == '0);
        sts[`VAC_STS_YIN] = (y_q[DW-1 -: `VAC_TOP_BITS] == '0);
    end

    logic [DW-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (rsel)
            VAC_SEL_NONE: rd_mux = '0;
            VAC_SEL_BUF: rd_mux = buf_q;
            VAC_SEL_CTL: rd_mux = ctl_q;
            VAC_SEL_STS: rd_mux = sts;
            VAC_SEL_STEP: rd_mux = {{(DW-SW){1'b0}}, step_q};
            VAC_SEL_DY: rd_mux = dy_q;
            VAC_SEL_Y: rd_mux = y_q;
            VAC_SEL_X: rd_mux = x_q;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= rd_mux;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            x_axis_read_strobe_o <= 1'b0;
            y_axis_read_strobe_o <= 1'b0;
            dy_axis_read_strobe_o <= 1'b0;
        end else if (ce_i) begin
            x_axis_read_strobe_o <= (rsel == VAC_SEL_X);
            y_axis_read_strobe_o <= (rsel == VAC_SEL_Y);
            dy_axis_read_strobe_o <= (rsel == VAC_SEL_DY);
        end
    end

endmodule

`default_nettype wire

// *** verification/vac_axis_counters_assertions.sv ***
// Purpose: port-level checks of the axis counter block
// Assumes: ce_i high while strobes are checked
// Notes: bound to the design top below the module
`timescale 1ns/1ps
`default_nettype none
`include "vac_cfg.svh"
module vac_axis_counters_chk
    import vac_pkg::*;
#(
    parameter int DW = `VAC_DW
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire vac_bus_t bus_i,
    input wire vac_ctl_t ctl_i,
    input wire vac_slope_t slope_i,
    input wire logic x_axis_read_strobe_o,
    input wire logic y_axis_read_strobe_o,
    input wire logic dy_axis_read_strobe_o,
    input wire logic count_empty_flag_o,
    input wire logic pixel_count_empty_flag_o,
    input wire logic y_count_enable_o,
    input wire logic first_step_o,
    input wire logic vector_active_o,
    input wire logic vector_end_o,
    input wire logic x_step_request_test_n_o,
    input wire logic y_step_request_test_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_counting;
        ce_i && ctl_i.x_count_enable && !ctl_i.x_axis_load_strobe;
    endsequence

    a_x_read_strobe: assert property (ce_i && bus_i.rd && bus_i.addr == `VAC_OFF_X |=> x_axis_read_strobe_o) else $error("x read strobe missing");
    a_x_strobe_cause: assert property (x_axis_read_strobe_o |-> $past(bus_i.rd) && $past(bus_i.addr) == `VAC_OFF_X) else $error("stray x read strobe");
    a_y_read_strobe: assert property (ce_i && bus_i.rd && bus_i.addr == `VAC_OFF_Y |=> y_axis_read_strobe_o && !x_axis_read_strobe_o) else $error("y read strobe wrong");
    a_dy_read_strobe: assert property (ce_i && bus_i.rd && bus_i.addr == `VAC_OFF_DY |=> dy_axis_read_strobe_o && !y_axis_read_strobe_o) else $error("delta-y read strobe wrong");
    a_empty_gated: assert property ((count_empty_flag_o || pixel_count_empty_flag_o) && $past(ce_i) |-> $past(ctl_i.empty_detect_enable)) else $error("empty flag without enable");
    a_step_tests: assert property ($past(ce_i) |-> x_step_request_test_n_o == !$past(slope_i.x_step_request) && y_step_request_test_n_o == !$past(slope_i.y_step_request)) else $error("step test copies wrong");
    a_ycount_cause: assert property (y_count_enable_o |-> $past(ctl_i.x_count_enable) && $past(slope_i.y_step_request)) else $error("y count enable without cause");
    a_first_on_load: assert property (ce_i && ctl_i.x_axis_load_strobe |-> ##[1:2] first_step_o) else $error("first flag not set by load");
    a_first_cleared: assert property (s_counting [*2] |=> !first_step_o) else $error("first flag not cleared");
    a_end_single: assert property (vector_end_o |-> vector_active_o ##1 (!vector_active_o && !vector_end_o)) else $error("vector end pulse wrong");
endmodule
bind vac_axis_counters vac_axis_counters_chk #(.DW(DW)) u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .bus_i(bus_i), .ctl_i(ctl_i),
    .slope_i(slope_i), .x_axis_read_strobe_o(x_axis_read_strobe_o),
    .y_axis_read_strobe_o(y_axis_read_strobe_o), .dy_axis_read_strobe_o(dy_axis_read_strobe_o),
    .count_empty_flag_o(count_empty_flag_o), .pixel_count_empty_flag_o(pixel_count_empty_flag_o),
    .y_count_enable_o(y_count_enable_o), .first_step_o(first_step_o),
    .vector_active_o(vector_active_o), .vector_end_o(vector_end_o),
    .x_step_request_test_n_o(x_step_request_test_n_o),
    .y_step_request_test_n_o(y_step_request_test_n_o));
`default_nettype wire

// *** verification/vac_axis_counters_tb_top.sv ***
// Purpose: self-checking bench of the axis counter block
// Assumes: ce_i held high throughout
// Notes: draws short vectors and reads the axis registers back
`timescale 1ns/1ps
`default_nettype none
`include "vac_cfg.svh"
module vac_axis_counters_tb_top
    import vac_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    vac_bus_t bus = '0;
    vac_ctl_t ctl;
    vac_slope_t slope;
    logic go = 1'b0, xreq = 1'b1, yreq = 1'b0, slow = 1'b0, zen = 1'b0;
    logic ysel = 1'b0, yld = 1'b0, dyld = 1'b0;
    logic [15:0] rdata, disp, d;
    logic [2:0] strb;
    logic xin, yin_n, xs, ys, dys, cempty, pempty, ycnt, carry_n;
    logic first, active, vend, xtn, ytn, xdn, ydn;
    logic saw_carry = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;

    always #25 clk = ~clk;
    always @(posedge clk) if (carry_n === 1'b0) saw_carry <= 1'b1;

    vac_axis_counters uut (
        .clock_i(clk), .resetn_i(rstn), .ce_i(ce), .bus_i(bus), .rdata_o(rdata),
        .ctl_i(ctl), .slope_i(slope), .x_on_screen_flag_o(xin),
        .y_on_screen_flag_n_o(yin_n), .x_axis_read_strobe_o(xs),
        .y_axis_read_strobe_o(ys), .dy_axis_read_strobe_o(dys),
        .count_empty_flag_o(cempty), .pixel_count_empty_flag_o(pempty),
        .y_count_enable_o(ycnt), .x_carry_out_n_o(carry_n), .first_step_o(first),
        .vector_active_o(active), .vector_end_o(vend), .display_bus_o(disp),
        .x_step_request_test_n_o(xtn), .y_step_request_test_n_o(ytn),
        .x_direction_test_n_o(xdn), .y_direction_test_n_o(ydn));

    vac_ctl_model partner (
        .clock_i(clk), .resetn_i(rstn), .go_i(go), .xreq_i(xreq), .yreq_i(yreq),
        .slow_i(slow), .zen_i(zen), .ysel_i(ysel), .yld_i(yld), .dyld_i(dyld),
        .active_i(active), .ctl_o(ctl), .slope_o(slope));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input vac_addr_t a, input vac_word_t v);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // read data and strobes stand only in the cycle after the strobe;
    // taken at the edge closing that cycle, before the design updates
    task automatic rd(input vac_addr_t a);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
        strb = {xs, ys, dys};
    endtask

    task automatic pulse_load(input logic to_y);
        @(posedge clk);
        if (to_y) yld <= 1'b1;
        else dyld <= 1'b1;
        @(posedge clk);
        yld <= 1'b0;
        dyld <= 1'b0;
    endtask

    task automatic draw(input logic [15:0] xv, input logic [11:0] n);
        int i;
        wr(`VAC_OFF_STEP, {4'h0, n});
        wr(`VAC_OFF_BUF, xv);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 80 && vend !== 1'b1; i++) @(negedge clk);
        if (vend !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(16'hF70E);
        check("unmapped", d, 16'h0000);
        wr(`VAC_OFF_BUF, 16'hF234);
        pulse_load(1'b1);
        wr(`VAC_OFF_BUF, 16'h0ABC);
        pulse_load(1'b0);
        rd(`VAC_OFF_Y);
        check("y", d, 16'hF234);
        check("y strobe", {13'h0, strb}, 16'h0002);
        rd(`VAC_OFF_DY);
        check("dy", d, 16'h0ABC);
        check("dy strobe", {13'h0, strb}, 16'h0001);
        check("y off screen", {15'h0, yin_n}, 16'h0001);
        ysel <= 1'b1;
        repeat (3) @(posedge clk);
        check("display y", disp, 16'hF234);
        ysel <= 1'b0;
        repeat (3) @(posedge clk);
        check("display dy", disp, 16'h0ABC);
        // up-counting vector across the screen edge
        wr(`VAC_OFF_CTL, 16'h0000);
        draw(16'h1FFF, 12'h003);
        check("dir tests", {14'h0, xdn, ydn}, 16'h0003);
        rd(`VAC_OFF_X);
        check("x up", d, 16'h2002);
        check("x strobe", {13'h0, strb}, 16'h0004);
        check("x off screen", {15'h0, xin}, 16'h0000);
        // both axes down, x wraps through zero
        wr(`VAC_OFF_CTL, 16'h0003);
        wr(`VAC_OFF_BUF, 16'h0002);
        pulse_load(1'b1);
        yreq <= 1'b1;
        draw(16'h0001, 12'h002);
        yreq <= 1'b0;
        check("dir tests", {14'h0, xdn, ydn}, 16'h0000);
        rd(`VAC_OFF_X);
        check("x down", d, 16'hFFFF);
        rd(`VAC_OFF_Y);
        check("y down", d, 16'h0000);
        check("y on screen", {15'h0, yin_n}, 16'h0000);
        check("carry seen", {15'h0, saw_carry}, 16'h0001);
        // slow vector empties both counters, flags gated
        wr(`VAC_OFF_CTL, 16'h0000);
        slow <= 1'b1;
        draw(16'h0002, 12'h002);
        slow <= 1'b0;
        check("gated empties", {14'h0, cempty, pempty}, 16'h0000);
        check("x on screen", {15'h0, xin}, 16'h0001);
        check("inactive", {15'h0, active}, 16'h0000);
        zen <= 1'b1;
        repeat (3) @(posedge clk);
        check("empties", {14'h0, cempty, pempty}, 16'h0003);
        zen <= 1'b0;
        rd(`VAC_OFF_X);
        check("x slow", d, 16'h0004);
        rd(`VAC_OFF_STS);
        check("status", d, 16'h003C);
        stop_test();
    end
endmodule
`default_nettype wire

// *** verification/vac_ctl_model.sv ***
// Purpose: state controller and slope generator stand-in
// Assumes: go_i is a one-cycle pulse
// Notes: keeps counting until the block reports the vector inactive
`timescale 1ns/1ps
`default_nettype none
module vac_ctl_model
    import vac_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic go_i,
    input wire logic xreq_i,
    input wire logic yreq_i,
    input wire logic slow_i,
    input wire logic zen_i,
    input wire logic ysel_i,
    input wire logic yld_i,
    input wire logic dyld_i,
    input wire logic active_i,
    output var vac_ctl_t ctl_o,
    output var vac_slope_t slope_o
);
    logic ld_q;
    logic run_q;
    logic pace_q;
    logic [1:0] hold_q;

    // hold covers the cycles before the block shows the vector active
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ld_q <= 1'b0;
            run_q <= 1'b0;
            pace_q <= 1'b0;
            hold_q <= 2'h0;
        end else begin
            ld_q <= go_i;
            hold_q <= go_i ? 2'h3 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
            run_q <= go_i || (run_q && (hold_q != 2'h0 || active_i));
            pace_q <= slow_i && !pace_q;
        end
    end

    always_comb begin
        ctl_o.x_axis_load_strobe = ld_q;
        ctl_o.y_load = yld_i;
        ctl_o.dy_load = dyld_i;
        ctl_o.x_count_enable = run_q;
        ctl_o.empty_detect_enable = zen_i;
        ctl_o.y_select = ysel_i;
        slope_o.x_step_request = run_q && xreq_i && !pace_q;
        slope_o.y_step_request = run_q && yreq_i && !pace_q;
    end
endmodule
`default_nettype wire
